// *** pkg/hib_pkg.sv ***
// Constants shared by the hibernation power and seconds counter controller
package hib_pkg;

    // ****************************************
    // Bus widths
    // ****************************************
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [8:0] OFF_COUNTER  = 9'h000;
    localparam logic [8:0] OFF_MATCH0   = 9'h004;
    localparam logic [8:0] OFF_MATCH1   = 9'h008;
    localparam logic [8:0] OFF_LOAD     = 9'h00C;
    localparam logic [8:0] OFF_CONTROL  = 9'h010;
    localparam logic [8:0] OFF_MASK     = 9'h014;
    localparam logic [8:0] OFF_RAW      = 9'h018;
    localparam logic [8:0] OFF_MASKED   = 9'h01C;
    localparam logic [8:0] OFF_CLEAR    = 9'h020;
    localparam logic [8:0] OFF_TRIM     = 9'h024;
    localparam logic [8:0] OFF_DATA_LO  = 9'h030;
    localparam logic [8:0] OFF_DATA_HI  = 9'h12C;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int CTL_W               = 8;
    localparam int CTL_COUNTER_EN      = 0;
    localparam int CTL_SLEEP_REQ       = 1;
    localparam int CTL_SRC_SEL         = 2;
    localparam int CTL_MATCH_WAKE_EN   = 3;
    localparam int CTL_PIN_WAKE_EN     = 4;
    localparam int CTL_LOW_BATT_DET_EN = 5;
    localparam int CTL_OSC_EN          = 6;
    localparam int CTL_LOW_BATT_ABORT  = 7;

    // ****************************************
    // Event fields (raw, masked, mask, clear)
    // ****************************************
    localparam int EV_W        = 4;
    localparam int EV_MATCH0   = 0;
    localparam int EV_MATCH1   = 1;
    localparam int EV_LOW_BATT = 2;
    localparam int EV_WAKE_PIN = 3;

    // ****************************************
    // Reset values and timebase counts
    // ****************************************
    localparam logic [31:0] RST_MATCH   = 32'hFFFFFFFF;
    localparam logic [31:0] RST_LOAD    = 32'hFFFFFFFF;
    localparam logic [15:0] RST_TRIM    = 16'h7FFF;
    localparam logic [15:0] NOMINAL_DIV = 16'h7FFF;
    localparam logic [6:0]  XTAL_DIV_LAST = 7'h7F;
    localparam logic [5:0]  TRIM_SLOT   = 6'h00;
    localparam int          DATA_WORDS  = 64;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_ENTER = 2'b01,
        ST_SLEEP = 2'b11,
        ST_WAKE  = 2'b10
    } power_state_e;

endpackage

// *** logic/hib_power_ctrl.sv ***
// Hibernation power sequencer with seconds counter, event status and retained words
// ****************************************
// Overview of operation
// ****************************************
//
// Overview of operation
// - Reads are accepted back to back with no spacing.
// - An external clock source drives the timebase in every configuration.
// - Crystal input is divided by 128 to form the timebase.
// - Source runs only when enabled; select 0 divided crystal, 1 direct oscillator.
// - With detection enabled, low battery sets the low-battery raw flag.
// - Low-battery abort with a detected low battery refuses hibernation.
// - No battery checks while hibernating.
// - 32-bit seconds counter increments once per predivided second.
// - Predivider counts down ticks; trim divisor used one second in 64.
// - Trim above nominal lengthens the second, below shortens it.
// - Two match values; match raises an event in any state and, with match wake enabled, wakes from sleep.
// - Counter advances only when enabled; load write replaces it any time.
// - 64 read/write retained words kept through hibernation.
// - Sleep request starts hibernation and drives regulator enable low.
// - Pin wake and match wake enables, singly or together.
// - Wake releases regulator enable; raw status keeps the wake cause.
// - Wake pin, match and low-battery events ORed into one request.
// - Mask selects events; masked shows enabled pending, raw shows all.
// - Writing one to a clear bit clears that pending event.
// - Source select sits at control bit 2.
module hib_power_ctrl
    import hib_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              osc_in,
    input  wire logic              wake_n,
    input  wire logic              low_batt_in,
    output logic                   regulator_enable_n,
    output logic                   hibernating,
    output logic                   irq
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Each pin passes three flops; the filtered level moves only when the
    // last two agree. A crystal near 4.2 MHz is close to what a 10 MHz
    // sampler can follow, so the direct oscillator path is the safer one.
    localparam int NPIN = 3;
    // Flops start at each pin's idle level so no false edge follows reset
    localparam logic [NPIN-1:0] PIN_IDLE = 3'h2;
    wire  logic [NPIN-1:0] pin_raw;
    wire  logic [NPIN-1:0] pin_filt;
    assign pin_raw = {low_batt_in, wake_n, osc_in};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic filt_reg;
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    s1_reg   <= PIN_IDLE[gi];
                    s2_reg   <= PIN_IDLE[gi];
                    s3_reg   <= PIN_IDLE[gi];
                    filt_reg <= PIN_IDLE[gi];
                end else begin
                    s1_reg <= pin_raw[gi];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        filt_reg <= s3_reg;
                    end
                end
            end
            assign pin_filt[gi] = filt_reg;
        end
    endgenerate

    wire logic osc_lvl;
    wire logic wake_n_lvl;
    wire logic low_batt_lvl;
    assign osc_lvl      = pin_filt[0];
    assign wake_n_lvl   = pin_filt[1];
    assign low_batt_lvl = pin_filt[2];

    // ****************************************
    // Register state
    // ****************************************
    logic [CTL_W-1:0]  ctl_reg;
    logic [CTL_W-1:0]  ctl_next;
    logic [31:0]       count_reg;
    logic [31:0]       count_next;
    logic [31:0]       match0_reg;
    logic [31:0]       match1_reg;
    logic [31:0]       load_reg;
    logic [15:0]       trim_reg;
    logic [EV_W-1:0]   mask_reg;
    logic [EV_W-1:0]   raw_reg;
    logic [EV_W-1:0]   raw_next;
    logic [15:0]       prediv_reg;
    logic [15:0]       prediv_next;
    logic [5:0]        sec_slot_reg;
    logic [6:0]        xdiv_reg;
    logic              osc_prev_reg;
    logic              wake_prev_reg;
    logic [1:0]        match_prev_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [31:0]       words [DATA_WORDS];
    power_state_e      state_reg;
    power_state_e      state_next;

    // ****************************************
    // Address decode
    // ****************************************
    wire logic hit_count;
    wire logic hit_m0;
    wire logic hit_m1;
    wire logic hit_load;
    wire logic hit_ctl;
    wire logic hit_mask;
    wire logic hit_raw;
    wire logic hit_masked;
    wire logic hit_clear;
    wire logic hit_trim;
    wire logic hit_data;
    wire logic [5:0] word_idx;
    wire logic [ADDR_W-1:0] data_off;

    assign hit_count  = (addr == OFF_COUNTER);
    assign hit_m0     = (addr == OFF_MATCH0);
    assign hit_m1     = (addr == OFF_MATCH1);
    assign hit_load   = (addr == OFF_LOAD);
    assign hit_ctl    = (addr == OFF_CONTROL);
    assign hit_mask   = (addr == OFF_MASK);
    assign hit_raw    = (addr == OFF_RAW);
    assign hit_masked = (addr == OFF_MASKED);
    assign hit_clear  = (addr == OFF_CLEAR);
    assign hit_trim   = (addr == OFF_TRIM);
    assign hit_data   = (addr >= OFF_DATA_LO) && (addr <= OFF_DATA_HI) && (addr[1:0] == 2'h0);
    assign data_off   = addr - OFF_DATA_LO;
    assign word_idx   = data_off[7:2];

    // ****************************************
    // Timebase
    // ****************************************
    wire logic osc_rise;
    wire logic osc_en;
    wire logic src_sel;
    wire logic tick;
    assign osc_en   = ctl_reg[CTL_OSC_EN];
    assign src_sel  = ctl_reg[CTL_SRC_SEL];
    assign osc_rise = osc_lvl && !osc_prev_reg;
    assign tick     = osc_en && osc_rise && (src_sel || (xdiv_reg == XTAL_DIV_LAST));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osc_prev_reg <= 1'b0;
            xdiv_reg     <= 7'h00;
        end else begin
            osc_prev_reg <= osc_lvl;
            if (osc_en && !src_sel && osc_rise) begin
                xdiv_reg <= xdiv_reg + 7'h01;
            end
        end
    end

    // ****************************************
    // Predivider and seconds counter
    // ****************************************
    // A reload value D gives a second of D+1 ticks, so the nominal value
    // yields exactly 32768 ticks and each trim step moves one tick.
    wire logic        cnt_en;
    wire logic        sec_done;
    wire logic [15:0] reload_val;
    wire logic [5:0]  slot_after;
    wire logic        load_wr;
    assign cnt_en     = ctl_reg[CTL_COUNTER_EN];
    assign sec_done   = tick && cnt_en && (prediv_reg == 16'h0000);
    assign slot_after = sec_slot_reg + 6'h01;
    assign reload_val = (slot_after == TRIM_SLOT) ? trim_reg : NOMINAL_DIV;
    assign load_wr    = wr && hit_load;

    always_comb begin
        prediv_next = prediv_reg;
        if (tick && cnt_en) begin
            prediv_next = sec_done ? reload_val : (prediv_reg - 16'h0001);
        end
        count_next = count_reg;
        if (load_wr) begin
            count_next = wdata;
        end else if (sec_done) begin
            count_next = count_reg + 32'h00000001;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prediv_reg   <= NOMINAL_DIV;
            sec_slot_reg <= 6'h00;
            count_reg    <= 32'h00000000;
        end else begin
            prediv_reg <= prediv_next;
            count_reg  <= count_next;
            if (sec_done) begin
                sec_slot_reg <= slot_after;
            end
        end
    end

    // ****************************************
    // Match detection and wake sources
    // ****************************************
    wire logic [1:0] match_lvl;
    wire logic [1:0] match_hit;
    wire logic       wake_fall;
    wire logic       wake_by_pin;
    wire logic       wake_by_match;
    wire logic       wake_any;
    assign match_lvl     = {count_reg == match1_reg, count_reg == match0_reg};
    assign match_hit     = match_lvl & ~match_prev_reg;
    assign wake_fall     = !wake_n_lvl && wake_prev_reg;
    assign wake_by_pin   = ctl_reg[CTL_PIN_WAKE_EN] && !wake_n_lvl;
    assign wake_by_match = ctl_reg[CTL_MATCH_WAKE_EN] && (|match_lvl);
    assign wake_any      = wake_by_pin || wake_by_match;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            match_prev_reg <= 2'b00;
            wake_prev_reg  <= 1'b1;
        end else begin
            match_prev_reg <= match_lvl;
            wake_prev_reg  <= wake_n_lvl;
        end
    end

    // ****************************************
    // Event status
    // ****************************************
    wire logic [EV_W-1:0] ev_set;
    wire logic [EV_W-1:0] ev_clr;
    wire logic            batt_check;
    wire logic [EV_W-1:0] masked;
    assign batt_check = ctl_reg[CTL_LOW_BATT_DET_EN] && (state_reg != ST_SLEEP);
    assign ev_set[EV_MATCH0]   = match_hit[0];
    assign ev_set[EV_MATCH1]   = match_hit[1];
    assign ev_set[EV_LOW_BATT] = batt_check && low_batt_lvl;
    assign ev_set[EV_WAKE_PIN] = wake_fall;
    assign ev_clr  = (wr && hit_clear) ? wdata[EV_W-1:0] : '0;
    assign masked  = raw_reg & mask_reg;

    // Set wins over a clear in the same cycle so no event is lost
    assign raw_next = (raw_reg & ~ev_clr) | ev_set;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            raw_reg <= '0;
        end else begin
            raw_reg <= raw_next;
        end
    end

    // ****************************************
    // Power sequencer
    // ****************************************
    wire logic abort_now;
    assign abort_now = ctl_reg[CTL_LOW_BATT_ABORT] && raw_reg[EV_LOW_BATT];

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (ctl_reg[CTL_SLEEP_REQ]) begin
                    state_next = ST_ENTER;
                end
            end
            ST_ENTER: begin
                state_next = abort_now ? ST_RUN : ST_SLEEP;
            end
            ST_SLEEP: begin
                if (wake_any) begin
                    state_next = ST_WAKE;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    // The request bit drops once the sequence ends, whether refused or
    // completed, so a fresh write is needed for the next attempt.
    wire logic req_done;
    assign req_done = ((state_reg == ST_ENTER) && abort_now) || (state_reg == ST_WAKE);

    always_comb begin
        ctl_next = ctl_reg;
        if (wr && hit_ctl) begin
            ctl_next = wdata[CTL_W-1:0];
        end
        if (req_done) begin
            ctl_next[CTL_SLEEP_REQ] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_reg    <= '0;
            match0_reg <= RST_MATCH;
            match1_reg <= RST_MATCH;
            load_reg   <= RST_LOAD;
            trim_reg   <= RST_TRIM;
            mask_reg   <= '0;
        end else begin
            ctl_reg <= ctl_next;
            if (wr && hit_m0) begin
                match0_reg <= wdata;
            end
            if (wr && hit_m1) begin
                match1_reg <= wdata;
            end
            if (load_wr) begin
                load_reg <= wdata;
            end
            if (wr && hit_trim) begin
                trim_reg <= wdata[15:0];
            end
            if (wr && hit_mask) begin
                mask_reg <= wdata[EV_W-1:0];
            end
        end
    end

    // ****************************************
    // Retained words
    // ****************************************
    // No reset on the array: its contents must survive every power cycle
    // of the main domain.
    always_ff @(posedge clk) begin
        if (wr && hit_data) begin
            words[word_idx] <= wdata;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    wire logic [DATA_W-1:0] rd_mux;
    assign rd_mux = hit_count  ? count_reg :
                    hit_m0     ? match0_reg :
                    hit_m1     ? match1_reg :
                    hit_load   ? load_reg :
                    hit_ctl    ? {{(DATA_W-CTL_W){1'b0}}, ctl_reg} :
                    hit_mask   ? {{(DATA_W-EV_W){1'b0}}, mask_reg} :
                    hit_raw    ? {{(DATA_W-EV_W){1'b0}}, raw_reg} :
                    hit_masked ? {{(DATA_W-EV_W){1'b0}}, masked} :
                    hit_trim   ? {16'h0000, trim_reg} :
                    hit_data   ? words[word_idx] :
                    32'h00000000;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= '0;
        end else if (rd) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= '0;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdata              = rdata_reg;
    assign hibernating        = (state_reg == ST_SLEEP);
    assign regulator_enable_n = (state_reg != ST_SLEEP);
    assign irq                = |masked;

endmodule

// *** verif/hib_ctrl_properties.sv ***
// Port checker for the hibernation power controller
module hib_ctrl_properties
    import hib_pkg::*;
(
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              osc_in,
    input wire logic              wake_n,
    input wire logic              low_batt_in,
    input wire logic              regulator_enable_n,
    input wire logic              hibernating,
    input wire logic              irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // Shadows of software settings
    // ****************************************
    // Hardware clears the sleep request, so only bits 7:2 are compared
    logic [CTL_W-1:0] ctl_reg;
    logic [EV_W-1:0]  mask_reg;
    wire logic        ctl_wr  = wr && addr == OFF_CONTROL;
    wire logic        mask_wr = wr && addr == OFF_MASK;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_reg  <= '0;
            mask_reg <= '0;
        end else begin
            if (ctl_wr) ctl_reg <= wdata[CTL_W-1:0];
            if (mask_wr) mask_reg <= wdata[EV_W-1:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_sleep_req;
        ctl_wr && wdata[CTL_SLEEP_REQ] && !wdata[CTL_LOW_BATT_ABORT] && regulator_enable_n && !hibernating;
    endsequence
    sequence s_power_cut;
        ##1 regulator_enable_n ##1 regulator_enable_n ##1 (!regulator_enable_n && hibernating);
    endsequence
    a_sleep_entry_delay: assert property (s_sleep_req |-> s_power_cut)
        else $error("regulator enable did not drop two edges after sleep request");
    a_level_pair: assert property (regulator_enable_n == !hibernating)
        else $error("regulator enable disagrees with hibernating");
    a_pin_wake_bound: assert property ($fell(wake_n) && hibernating && ctl_reg[CTL_PIN_WAKE_EN]
        |-> ##[1:8] regulator_enable_n)
        else $error("wake pin did not restore power");
    a_wake_holds_run: assert property ($fell(hibernating) |-> !hibernating [*2])
        else $error("sleep resumed right after wake");
    a_irq_masked_off: assert property (mask_reg == '0 |-> !irq)
        else $error("interrupt raised with all events masked");
    a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == '0)
        else $error("read data outside its answer cycle");
    a_unmapped_zero: assert property (rd && (addr > OFF_DATA_HI || addr == OFF_CLEAR
        || addr == 9'h028 || addr == 9'h02C) |=> rdata == '0)
        else $error("unmapped or clear read not zero");
    a_mask_readback: assert property (rd && addr == OFF_MASK
        |=> rdata == {{(DATA_W-EV_W){1'b0}}, mask_reg})
        else $error("event mask read back wrong");
    a_ctl_field_readback: assert property (rd && addr == OFF_CONTROL
        |=> rdata[CTL_W-1:CTL_SRC_SEL] == ctl_reg[CTL_W-1:CTL_SRC_SEL])
        else $error("control bits read back wrong");
endmodule

// *** verif/far_side_model.sv ***
// Far side: oscillator, wake pin with pull-up, battery comparator
module far_side_model (
    input  wire logic press_wake,
    input  wire logic batt_low,
    output logic      osc_in,
    output logic      wake_n,
    output logic      low_batt_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Oscillator runs free, phase unrelated to the bus clock
    initial begin
        osc_in = 1'b0;
        forever #731 osc_in = ~osc_in;
    end
    // Weak pull-up keeps the pin high unless pressed
    assign wake_n      = press_wake ? 1'b0 : 1'b1;
    assign low_batt_in = batt_low;
endmodule

// *** verif/tb_top.sv ***
// Self-checking testbench for the hibernation power controller
module tb_top
    import hib_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Gap kept after every write so slow registers settle
    localparam int GAP = 3;
    localparam logic [8:0] RA [11] = '{OFF_COUNTER, OFF_MATCH0, OFF_MATCH1, OFF_LOAD, OFF_CONTROL,
        OFF_MASK, OFF_RAW, OFF_MASKED, OFF_CLEAR, OFF_TRIM, 9'h028};
    localparam logic [31:0] RV [11] = '{32'h0, RST_MATCH, RST_MATCH, RST_LOAD, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0, {16'h0, RST_TRIM}, 32'h0};
    logic              clk;
    logic              nrst       = 1'b0;
    logic [ADDR_W-1:0] addr       = '0;
    logic [DATA_W-1:0] wdata      = '0;
    logic              wr         = 1'b0;
    logic              rd         = 1'b0;
    logic              press_wake = 1'b0;
    logic              batt_low   = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic              osc_in, wake_n, low_batt_in, regulator_enable_n, hibernating, irq;
    int                fail_count = 0;
    int                num_checks = 0;

    hib_power_ctrl dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .osc_in(osc_in), .wake_n(wake_n), .low_batt_in(low_batt_in),
        .regulator_enable_n(regulator_enable_n), .hibernating(hibernating), .irq(irq));
    far_side_model far_u (.press_wake(press_wake), .batt_low(batt_low), .osc_in(osc_in),
        .wake_n(wake_n), .low_batt_in(low_batt_in));

    // ****************************************
    // Bus tasks and checks
    // ****************************************
    task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic write_reg(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        repeat (GAP) @(posedge clk);
        #1;
    endtask
    task automatic check_reg(input logic [8:0] a, input logic [31:0] exp, input string name);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 compare(name, exp, rdata);
    endtask
    task automatic wait_power(input logic level);
        repeat (50) if (regulator_enable_n !== level) begin
            @(posedge clk);
            #1;
        end
        compare("regulator_enable_n", 32'(level), 32'(regulator_enable_n));
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Whole run is about two hundred cycles; over twenty times that marks a hang
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        conclude();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        foreach (RA[i]) check_reg(RA[i], RV[i], "reset value");
        compare("regulator_enable_n", 32'h1, 32'(regulator_enable_n));
        $display("test reset values done");
        write_reg(OFF_MATCH0, 32'h1234ABCD);
        write_reg(OFF_DATA_LO, 32'hA5A5F00F);
        write_reg(OFF_DATA_HI, 32'h0F0F5A5A);
        write_reg(OFF_COUNTER, 32'h00000055);
        write_reg(OFF_TRIM, 32'h00008123);
        check_reg(OFF_MATCH0, 32'h1234ABCD, "match_zero");
        check_reg(OFF_DATA_LO, 32'hA5A5F00F, "retained_words");
        check_reg(OFF_DATA_HI, 32'h0F0F5A5A, "retained_words");
        check_reg(OFF_COUNTER, 32'h0, "seconds_counter");
        check_reg(OFF_TRIM, 32'h00008123, "predivider_trim");
        $display("test storage done");
        write_reg(OFF_CONTROL, 32'h00000044);
        check_reg(OFF_CONTROL, 32'h00000044, "power_control_reg");
        write_reg(OFF_MASK, 32'h00000001);
        write_reg(OFF_MATCH1, 32'h00000200);
        write_reg(OFF_LOAD, 32'h1234ABCD);
        check_reg(OFF_COUNTER, 32'h1234ABCD, "seconds_counter");
        write_reg(OFF_LOAD, 32'h00000200);
        check_reg(OFF_RAW, 32'h00000003, "raw_event_status");
        check_reg(OFF_MASKED, 32'h00000001, "masked_event_status");
        compare("irq", 32'h1, 32'(irq));
        write_reg(OFF_CLEAR, 32'h00000001);
        check_reg(OFF_RAW, 32'h00000002, "raw_event_status");
        check_reg(OFF_MASKED, 32'h0, "masked_event_status");
        compare("irq", 32'h0, 32'(irq));
        check_reg(OFF_COUNTER, 32'h00000200, "seconds_counter");
        $display("test match events done");
        @(posedge clk);
        batt_low <= 1'b1;
        write_reg(OFF_CLEAR, 32'h0000000F);
        write_reg(OFF_CONTROL, 32'h00000064);
        check_reg(OFF_RAW, 32'h00000004, "raw_event_status");
        write_reg(OFF_MASK, 32'h00000004);
        compare("irq", 32'h1, 32'(irq));
        write_reg(OFF_CONTROL, 32'h000000F6);
        compare("regulator_enable_n", 32'h1, 32'(regulator_enable_n));
        check_reg(OFF_CONTROL, 32'h000000F4, "power_control_reg");
        $display("test low battery abort done");
        write_reg(OFF_MASK, 32'h0);
        write_reg(OFF_CONTROL, 32'h00000076);
        wait_power(1'b0);
        write_reg(OFF_CLEAR, 32'h0000000F);
        check_reg(OFF_RAW, 32'h0, "raw_event_status");
        @(posedge clk);
        batt_low <= 1'b0;
        repeat (6) @(posedge clk);
        press_wake <= 1'b1;
        wait_power(1'b1);
        compare("hibernating", 32'h0, 32'(hibernating));
        @(posedge clk);
        press_wake <= 1'b0;
        check_reg(OFF_RAW, 32'h00000008, "raw_event_status");
        check_reg(OFF_DATA_HI, 32'h0F0F5A5A, "retained_words");
        check_reg(OFF_CONTROL, 32'h00000074, "power_control_reg");
        $display("test pin wake done");
        write_reg(OFF_LOAD, 32'h0);
        write_reg(OFF_CLEAR, 32'h0000000F);
        write_reg(OFF_CONTROL, 32'h0000004E);
        wait_power(1'b0);
        write_reg(OFF_LOAD, 32'h00000200);
        wait_power(1'b1);
        check_reg(OFF_RAW, 32'h00000002, "raw_event_status");
        $display("test match wake done");
        conclude();
    end
endmodule

bind hib_power_ctrl hib_ctrl_properties chk_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .osc_in(osc_in), .wake_n(wake_n), .low_batt_in(low_batt_in),
    .regulator_enable_n(regulator_enable_n), .hibernating(hibernating), .irq(irq));
